// File: wrf_cfg.svh
// Register map, field positions, reset values and timing counts of the watchdog block.
`ifndef WRF_CFG_SVH
`define WRF_CFG_SVH

`define WRF_ADDR_W 8
`define WRF_ADDR_CAUSE 8'h00
`define WRF_ADDR_CTRL 8'h01

`define WRF_CAUSE_SCAN 4
`define WRF_CAUSE_DOG 3
`define WRF_CAUSE_LOW_SUPPLY 2
`define WRF_CAUSE_PIN 1
`define WRF_CAUSE_POWER_UP 0
`define WRF_CAUSE_RESET 5'h01

`define WRF_CTRL_IRQ_FLAG 7
`define WRF_CTRL_IRQ_EN 6
`define WRF_CTRL_PERIOD_HI 5
`define WRF_CTRL_UNLOCK 4
`define WRF_CTRL_RESET_EN 3

`define WRF_PERIOD_RESET 4'h0
`define WRF_PERIOD_MAX 4'h9
`define WRF_TIMEOUT_BASE 21'h000800
`define WRF_CNT_W 21

`define WRF_UNLOCK_CYCLES 3'h4

`define WRF_CLK_HZ 25000000
`define WRF_OSC_HZ 128000
`define WRF_OSC_DIV (`WRF_CLK_HZ / `WRF_OSC_HZ)
`define WRF_DIV_W 8

`endif

// File: wrf_pkg.sv
// Types shared by the watchdog and reset-flag block.
package wrf_pkg;

	typedef enum logic [1:0] {
		WRF_STOPPED,
		WRF_IRQ_MODE,
		WRF_RESET_MODE,
		WRF_IRQ_RESET_MODE
	} wrf_mode_type;

	typedef struct packed {
		logic scan_port;
		logic low_supply;
		logic pin;
	} wrf_reset_events_type;

endpackage : wrf_pkg

// File: wrf_watchdog.sv
// Watchdog timer with timed change protection and reset-cause flags.
//
// How it works
// - Scan-port reset flag sets on a scan chain reset; power-up or zero-write clears.
// - Dog reset flag sets on a watchdog reset; power-up or zero-write clears.
// - Low-supply reset flag sets on brown-out reset; power-up or zero-write clears.
// - Pin reset flag sets on external reset; power-up or zero-write clears.
// - Power-up flag sets on power-up; only a zero-write clears it.
// - Timeout irq flag sets on a timeout in interrupt operation.
// - Timeout irq flag clears on vector execution or on writing one.
// - Interrupt request needs flag, irq enable and global enable all set.
// - Without the fuse, reset enable and irq enable select one of four modes.
// - Vector in combined mode clears irq enable and flag, leaving reset mode.
// - Combined mode resets when a timeout finds the flag still pending.
// - Reset enable clears and period changes only while unlocked, or on any reset event.
// - Unlock bit clears itself four clock cycles after being written.
// - Reset enable reads one and cannot clear while dog reset flag is set.
// - Period code 0 to 9 selects 2048 up to 1048576 oscillator cycles.
// - Unlock takes a write of unlock and reset enable, then one write within four.
// - With the always-on fuse, reset mode is forced: reset enable one, irq enable zero.
// - Counter counts oscillator ticks and acts when the selected count is reached.
// - A restart pulse returns the counter to zero.
`timescale 1ns/1ps
`include "wrf_cfg.svh"

module wrf_watchdog #(
	parameter int OSC_DIV = `WRF_OSC_DIV
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [`WRF_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	output logic [7:0] o_rdata,
	input wire wrf_pkg::wrf_reset_events_type i_reset_events,
	input wire logic i_always_on_fuse,
	input wire logic i_restart,
	input wire logic i_global_irq_enable,
	input wire logic i_vector_taken,
	output logic o_irq,
	output logic o_system_reset
);

	localparam logic [`WRF_DIV_W-1:0] DIV_LAST = `WRF_DIV_W'(OSC_DIV - 1);

	logic [`WRF_DIV_W-1:0] div_reg;
	logic [`WRF_DIV_W-1:0] div_next;
	logic [`WRF_CNT_W-1:0] cnt_reg;
	logic [`WRF_CNT_W-1:0] cnt_next;
	logic [`WRF_CNT_W-1:0] limit;
	logic tick;
	logic timeout;

	logic irq_flag_reg;
	logic irq_flag_next;
	logic irq_en_reg;
	logic irq_en_next;
	logic reset_en_reg;
	logic reset_en_next;
	logic [3:0] period_reg;
	logic [3:0] period_next;
	logic [2:0] unlock_reg;
	logic [2:0] unlock_next;
	logic [4:0] cause_reg;
	logic [4:0] cause_next;
	logic [7:0] rdata_next;
	logic irq_next;
	logic sys_reset_next;

	logic unlocked;
	logic reset_en_eff;
	logic irq_en_eff;
	logic wr_ctrl;
	logic wr_cause;
	logic irq_set;
	logic dog_reset;
	logic any_reset;
	logic [7:0] ctrl_view;
	wrf_pkg::wrf_mode_type mode;

	assign wr_ctrl = i_write && (i_addr == `WRF_ADDR_CTRL);
	assign wr_cause = i_write && (i_addr == `WRF_ADDR_CAUSE);
	assign unlocked = (unlock_reg != 3'h0);
	assign reset_en_eff = reset_en_reg | cause_reg[`WRF_CAUSE_DOG] | i_always_on_fuse;
	assign irq_en_eff = irq_en_reg & ~i_always_on_fuse;

	always_comb begin
		case ({reset_en_eff, irq_en_eff})
			2'b00: mode = wrf_pkg::WRF_STOPPED;
			2'b01: mode = wrf_pkg::WRF_IRQ_MODE;
			2'b10: mode = wrf_pkg::WRF_RESET_MODE;
			2'b11: mode = wrf_pkg::WRF_IRQ_RESET_MODE;
			default: mode = wrf_pkg::WRF_STOPPED;
		endcase
	end

	// Reserved codes saturate to the longest period rather than wrapping to a short one.
	always_comb begin
		if (period_reg > `WRF_PERIOD_MAX) begin
			limit = `WRF_TIMEOUT_BASE << `WRF_PERIOD_MAX;
		end else begin
			limit = `WRF_TIMEOUT_BASE << period_reg;
		end
	end

	// Oscillator tick divider and timeout counter.
	always_comb begin
		tick = (div_reg == DIV_LAST);
		div_next = tick ? '0 : div_reg + `WRF_DIV_W'(1);
		cnt_next = cnt_reg;
		timeout = 1'b0;
		// A shorter period than the present count fires on the next tick.
		if (mode == wrf_pkg::WRF_STOPPED) begin
			cnt_next = '0;
		end else if (tick) begin
			if (cnt_reg + `WRF_CNT_W'(1) >= limit) begin
				timeout = 1'b1;
				cnt_next = '0;
			end else begin
				cnt_next = cnt_reg + `WRF_CNT_W'(1);
			end
		end
		if (i_restart || any_reset) begin
			cnt_next = '0;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			div_reg <= '0;
			cnt_reg <= '0;
		end else begin
			div_reg <= div_next;
			cnt_reg <= cnt_next;
		end
	end

	always_comb begin
		irq_set = timeout && ((mode == wrf_pkg::WRF_IRQ_MODE) ||
			(mode == wrf_pkg::WRF_IRQ_RESET_MODE && !irq_flag_reg));
		dog_reset = timeout && ((mode == wrf_pkg::WRF_RESET_MODE) ||
			(mode == wrf_pkg::WRF_IRQ_RESET_MODE && irq_flag_reg));
		any_reset = dog_reset || i_reset_events.scan_port || i_reset_events.low_supply ||
			i_reset_events.pin;
	end

	// Control register: timed unlock, protected fields and the timeout interrupt flag.
	always_comb begin
		irq_flag_next = irq_flag_reg;
		irq_en_next = irq_en_reg;
		reset_en_next = reset_en_reg | cause_reg[`WRF_CAUSE_DOG];
		period_next = period_reg;
		unlock_next = unlocked ? unlock_reg - 3'h1 : 3'h0;
		if (wr_ctrl) begin
			irq_en_next = i_wdata[`WRF_CTRL_IRQ_EN];
			if (i_wdata[`WRF_CTRL_UNLOCK] && i_wdata[`WRF_CTRL_RESET_EN]) begin
				unlock_next = `WRF_UNLOCK_CYCLES;
				reset_en_next = 1'b1;
			end else begin
				if (i_wdata[`WRF_CTRL_RESET_EN]) begin
					reset_en_next = 1'b1;
				end else if (unlocked && !cause_reg[`WRF_CAUSE_DOG]) begin
					reset_en_next = 1'b0;
				end
				if (unlocked) begin
					period_next = {i_wdata[`WRF_CTRL_PERIOD_HI], i_wdata[2:0]};
					unlock_next = 3'h0;
				end
			end
			if (i_wdata[`WRF_CTRL_IRQ_FLAG]) begin
				irq_flag_next = 1'b0;
			end
		end
		if (i_vector_taken) begin
			irq_flag_next = 1'b0;
			if (mode == wrf_pkg::WRF_IRQ_RESET_MODE) begin
				irq_en_next = 1'b0;
			end
		end
		// A timeout in the same cycle as a clear keeps the flag set.
		if (irq_set) begin
			irq_flag_next = 1'b1;
		end
		if (any_reset) begin
			irq_flag_next = 1'b0;
			irq_en_next = 1'b0;
			reset_en_next = 1'b0;
			period_next = `WRF_PERIOD_RESET;
			unlock_next = 3'h0;
		end
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			irq_flag_reg <= 1'b0;
			irq_en_reg <= 1'b0;
			reset_en_reg <= 1'b0;
			period_reg <= `WRF_PERIOD_RESET;
			unlock_reg <= 3'h0;
		end else begin
			irq_flag_reg <= irq_flag_next;
			irq_en_reg <= irq_en_next;
			reset_en_reg <= reset_en_next;
			period_reg <= period_next;
			unlock_reg <= unlock_next;
		end
	end

	// Reset-cause flags: zero-writes clear, events set, and an event beats a clear.
	always_comb begin
		cause_next = cause_reg;
		if (wr_cause) begin
			cause_next = cause_reg & i_wdata[4:0];
		end
		if (i_reset_events.scan_port) begin
			cause_next[`WRF_CAUSE_SCAN] = 1'b1;
		end
		if (dog_reset) begin
			cause_next[`WRF_CAUSE_DOG] = 1'b1;
		end
		if (i_reset_events.low_supply) begin
			cause_next[`WRF_CAUSE_LOW_SUPPLY] = 1'b1;
		end
		if (i_reset_events.pin) begin
			cause_next[`WRF_CAUSE_PIN] = 1'b1;
		end
	end

	// The block reset is the power-up reset, so it sets the power-up flag and clears the other causes.
	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			cause_reg <= `WRF_CAUSE_RESET;
		end else begin
			cause_reg <= cause_next;
		end
	end

	// Read data, interrupt request and reset pulse.
	always_comb begin
		ctrl_view = {irq_flag_reg, irq_en_eff, period_reg[3], unlocked, reset_en_eff,
			period_reg[2:0]};
		rdata_next = 8'h00;
		if (i_read && i_addr == `WRF_ADDR_CAUSE) begin
			rdata_next = {3'h0, cause_reg};
		end else if (i_read && i_addr == `WRF_ADDR_CTRL) begin
			rdata_next = ctrl_view;
		end
		irq_next = irq_flag_reg && irq_en_eff && i_global_irq_enable;
		sys_reset_next = dog_reset;
	end

	always_ff @(posedge i_clock or posedge i_rst) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
			o_irq <= 1'b0;
			o_system_reset <= 1'b0;
		end else begin
			o_rdata <= rdata_next;
			o_irq <= irq_next;
			o_system_reset <= sys_reset_next;
		end
	end

endmodule : wrf_watchdog

// File: wrf_watchdog_checker.sv
// Concurrent checks on the ports of the watchdog block.
`timescale 1ns/1ps
`include "wrf_cfg.svh"
module wrf_watchdog_checker #(
	parameter int OSC_DIV = `WRF_OSC_DIV
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [`WRF_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_write,
	input wire logic i_read,
	input wire logic [7:0] o_rdata,
	input wire logic i_always_on_fuse,
	input wire logic i_global_irq_enable,
	input wire logic i_vector_taken,
	input wire logic o_irq,
	input wire logic o_system_reset
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	sequence s_unlock;
		i_write && i_addr == `WRF_ADDR_CTRL && i_wdata[4] && i_wdata[3];
	endsequence
	sequence s_rd_ctrl;
		i_read && i_addr == `WRF_ADDR_CTRL;
	endsequence
	AST_UNLOCK_READ: assert property (s_unlock ##1 !i_write ##1 s_rd_ctrl |=> o_rdata[4:3] == 2'h3)
		else $error("unlock not visible");
	AST_UNLOCK_EXPIRE: assert property (s_unlock ##1 (!i_write)[*6] ##0 s_rd_ctrl |=> !o_rdata[4])
		else $error("unlock did not expire");
	AST_FUSE_MODE: assert property (s_rd_ctrl ##0 i_always_on_fuse |=> !o_rdata[6] && o_rdata[3])
		else $error("fuse mode not forced");
	AST_CAUSE_TOP: assert property (i_read && i_addr == `WRF_ADDR_CAUSE |=> o_rdata[7:5] == 3'h0)
		else $error("unused cause bits set");
	AST_IRQ_GATE: assert property (o_irq |-> $past(i_global_irq_enable))
		else $error("irq without global enable");
	AST_IRQ_DROP: assert property ($fell(i_global_irq_enable) |=> !o_irq)
		else $error("irq stayed after global disable");
	AST_VECTOR_CLEAR: assert property (i_vector_taken |-> ##2 !o_irq)
		else $error("irq stayed after vector");
	AST_RESET_PULSE: assert property (o_system_reset |=> !o_system_reset)
		else $error("reset pulse too long");
endmodule : wrf_watchdog_checker

bind wrf_watchdog wrf_watchdog_checker #(.OSC_DIV(OSC_DIV)) u_chk (
	.i_clock(i_clock),
	.i_rst(i_rst),
	.i_addr(i_addr),
	.i_wdata(i_wdata),
	.i_write(i_write),
	.i_read(i_read),
	.o_rdata(o_rdata),
	.i_always_on_fuse(i_always_on_fuse),
	.i_global_irq_enable(i_global_irq_enable),
	.i_vector_taken(i_vector_taken),
	.o_irq(o_irq),
	.o_system_reset(o_system_reset)
);

// File: wrf_watchdog_and_reset_flags_test.sv
// Self-checking bench for the watchdog and reset-cause block.
`timescale 1ns/1ps
module watchdog_and_reset_flags_test;
	logic i_clock = 1'b0, i_rst = 1'b1, i_write = 1'b0, i_read = 1'b0;
	logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata, rd_val;
	wrf_pkg::wrf_reset_events_type i_reset_events = 3'h0;
	logic i_always_on_fuse = 1'b0, i_restart = 1'b0, i_vector_taken = 1'b0;
	logic i_global_irq_enable = 1'b1, o_irq, o_system_reset;
	int error_cnt = 0, n_checks = 0;
	logic [7:0] ev_exp [3] = '{8'h03, 8'h07, 8'h17};
	// Row: write flag, address, write data, expected read data.
	logic [27:0] rows [13] = '{
		28'h0_00_00_01,
		28'h0_01_00_00,
		28'h0_05_00_00,
		28'h1_00_00_00,
		28'h0_00_00_00,
		28'h1_01_0B_00,
		28'h1_01_00_00,
		28'h0_01_00_08,
		28'h1_01_18_00,
		28'h1_01_21_00,
		28'h0_01_00_21,
		28'h1_01_18_00,
		28'h1_01_40_00};
	wrf_watchdog #(.OSC_DIV(2)) u_dut (.*);
	always #20 i_clock = ~i_clock;
	task automatic give_verdict();
		if (error_cnt == 0 && n_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		i_write <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clock);
		i_write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_clock);
		i_read <= 1'b1;
		i_addr <= a;
		@(posedge i_clock);
		i_read <= 1'b0;
		#1;
		rd_val = o_rdata;
		if (exp !== 8'hXX) chk(exp, rd_val);
	endtask : rd
	task automatic pulse(input logic [4:0] v);
		@(posedge i_clock);
		{i_restart, i_vector_taken, i_reset_events} <= v;
		@(posedge i_clock);
		{i_restart, i_vector_taken, i_reset_events} <= 5'h00;
	endtask : pulse
	// The wait is bounded so a silent watchdog ends the run instead of hanging it.
	task automatic wt(input logic rs, input int lo, input int hi);
		int n;
		n = 0;
		do begin
			@(posedge i_clock);
			#1;
			n++;
		end while ((rs ? o_system_reset : o_irq) !== 1'b1 && n < 6000);
		chk(8'h01, {7'h00, n >= lo && n <= hi});
		if (n >= 6000) give_verdict();
	endtask : wt
	initial begin
		repeat (8) @(posedge i_clock);
		i_rst <= 1'b0;
		for (int r = 0; r < 13; r++) begin
			if (rows[r][24]) wr(rows[r][23:16], rows[r][15:8]);
			else rd(rows[r][23:16], rows[r][7:0]);
		end
		rd(8'h01, 8'h40);
		pulse(5'h10);
		wt(1'b0, 4080, 4120);
		rd(8'h01, 8'hC0);
		i_global_irq_enable <= 1'b0;
		repeat (2) @(posedge i_clock);
		#1 chk(8'h00, {7'h00, o_irq});
		wr(8'h01, 8'hC0);
		rd(8'h01, 8'h40);
		i_global_irq_enable <= 1'b1;
		repeat (6) begin
			pulse(5'h10);
			repeat (1000) @(posedge i_clock);
		end
		rd(8'h01, 8'h40);
		wr(8'h01, 8'h48);
		wt(1'b0, 1, 5999);
		pulse(5'h08);
		rd(8'h01, 8'h08);
		wr(8'h01, 8'h48);
		wt(1'b0, 1, 5999);
		wt(1'b1, 1, 5999);
		rd(8'h00, 8'h08);
		wr(8'h01, 8'h18);
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h08);
		wr(8'h00, 8'h00);
		wr(8'h01, 8'h18);
		wr(8'h01, 8'h00);
		rd(8'h01, 8'h00);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		rd(8'h00, 8'h01);
		for (int k = 0; k < 3; k++) begin
			pulse({2'h0, 3'h1 << k});
			rd(8'h00, ev_exp[k]);
		end
		wr(8'h01, 8'h18);
		rd(8'h01, 8'h18);
		repeat (2) @(posedge i_clock);
		rd(8'h01, 8'h08);
		i_always_on_fuse <= 1'b1;
		wr(8'h01, 8'h40);
		rd(8'h01, 8'h08);
		give_verdict();
	end
endmodule : watchdog_and_reset_flags_test
